// ==== rtl/bdm_pkg.sv ====
// constants, command codes and state types of the single-wire debug logic
// assumes one clock (mclk) and a synchronous active-high reset

package bdm_pkg;

  // operating mode bit values
  localparam logic MODE_NORMAL  = 1'b1;
  localparam logic MODE_SPECIAL = 1'b0;

  // bit timing, in target clock cycles
  localparam int CNT_W         = 10;
  localparam int LEN_W         = 8;
  localparam int RX_SAMPLE_CYC = 10;
  localparam int HOST_SAMPLE_CYC = 10;
  localparam int BIT0_LOW_CYC  = 13;
  localparam int SYNC_CYC      = 128;
  localparam int SYNC_RESP_CYC = 128;
  localparam int TIMEOUT_CYC   = 512;
  localparam int ACK_DELAY_CYC = 16;
  localparam int ACK_LOW_CYC   = 16;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // serial command codes
  localparam logic [7:0] CMD_ACK_ENABLE  = 8'hd5;
  localparam logic [7:0] CMD_ACK_DISABLE = 8'hd6;
  localparam logic [7:0] CMD_BACKGROUND  = 8'h90;
  localparam logic [7:0] CMD_GO          = 8'h08;
  localparam logic [7:0] CMD_STEP        = 8'h10;
  localparam logic [7:0] CMD_READ_STATUS = 8'he4;
  localparam logic [7:0] CMD_WRITE_MODE  = 8'hc4;

  // status byte and mode data byte layout
  localparam int STAT_MODE   = 0;
  localparam int STAT_ACK_EN = 1;
  localparam int STAT_STEPLP = 2;
  localparam int STAT_ACTIVE = 3;
  localparam int WMODE_BIT   = 0;

  typedef enum logic [3:0] {
    ST_IDLE, ST_RX, ST_SYNC_WAIT, ST_TX, ST_DRAIN,
    ST_ACK_WAIT, ST_ACK, ST_STEP
  } core_st_t;

  typedef struct packed {
    core_st_t           state;
    logic               rst_seen;
    logic               mode;
    logic               ack_en;
    logic               active;
    logic               fetch_vec;
    logic               periph_run;
    logic               step_lp;
    logic               step_irq;
    logic               step_req;
    logic               irq_stack;
    logic               isr_entry;
    logic               bit_open;
    logic               phase;
    logic [2:0]         nbits;
    logic [CNT_W-1:0]   cnt;
    logic [7:0]         shreg;
    logic [7:0]         cmd;
    logic               drv_go;
    logic [LEN_W-1:0]   drv_len;
  } core_state_t;

  localparam core_state_t CORE_RESET = '{state: ST_IDLE, rst_seen: 1'b1,
                                         default: '0};

endpackage

// ==== rtl/wire_if.sv ====
// signals between the pin synchroniser, the pulse driver and the core
// assumes all three parts run on mclk

`timescale 1ns/1ps

interface wire_if;
  import bdm_pkg::*;
  logic             level;
  logic             fall;
  logic             rise;
  logic             drv_go;
  logic [LEN_W-1:0] drv_len;
  logic             drv_busy;
  logic             drv_out;
  logic             drv_oe;

  modport sync (output level, output fall, output rise);
  modport drv  (input drv_go, input drv_len,
                output drv_busy, output drv_out, output drv_oe);
  modport core (input level, input fall, input rise,
                input drv_busy, input drv_out, input drv_oe,
                output drv_go, output drv_len);
endinterface

// ==== rtl/pin_sync.sv ====
// two-flop synchroniser and edge detector for the debug wire
// assumes the pin is asynchronous to mclk; not reset so it tracks the strap

`timescale 1ns/1ps

module pin_sync (
  // clock
  input  wire logic mclk,
  // pin level
  input  wire logic pin,
  // to core
  wire_if.sync      ifc
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb begin
    d    = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end

  assign ifc.level = q.s2;
  assign ifc.fall  = q.s3 & ~q.s2;
  assign ifc.rise  = ~q.s3 & q.s2;
endmodule

// ==== rtl/low_pulse_driver.sv ====
// drives the wire low for a given count, then high one cycle, then releases
// assumes go is a one-cycle pulse taken only while not busy

`timescale 1ns/1ps

module low_pulse_driver
  import bdm_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // core side
  wire_if.drv       ifc
);
  typedef struct packed {
    logic             busy;
    logic             out;
    logic             oe;
    logic [LEN_W-1:0] cnt;
  } drv_state_t;

  drv_state_t q;
  drv_state_t d;

  always_comb begin
    d = q;
    if (!q.busy) begin
      if (ifc.drv_go) begin
        d.busy = 1'b1;
        d.oe   = 1'b1;
        d.out  = 1'b0;
        d.cnt  = ifc.drv_len;
      end
    end else if (q.cnt > 8'h01) begin
      d.cnt = q.cnt - 8'h01;
    end else if (q.cnt == 8'h01) begin
      d.out = 1'b1;
      d.cnt = 8'h00;
    end else begin
      d.busy = 1'b0;
      d.oe   = 1'b0;
      d.out  = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ifc.drv_busy = q.busy;
  assign ifc.drv_out  = q.out;
  assign ifc.drv_oe   = q.oe;

  chk_rst_no_drive: assert property (
    @(posedge mclk) rst |=> !q.oe)
    else $error("wire driven during reset");
endmodule

// ==== rtl/background_debug_mode_logic.sv ====
// top of the single-wire background debugger target logic
// assumes cpu handshake inputs and sys_stop are on mclk; the wire is async

`timescale 1ns/1ps

// Contract
// - latch strap into mode bit at reset release
// - mode bit readable, only special-to-normal change
// - wire is strap input while reset held
// - special mode starts in active debug
// - normal mode boots from reset vector
// - bit starts at synchronised host falling edge
// - zero bit: low 13 cycles, then speedup high
// - step with pending interrupt only stacks
// - peripherals keep running while stepping
// - stepped stop or wait holds step open
// - in low power, all but background and step execute
// - system stop executes no command
// - low power exit enters debug at isr
// - no acknowledge for step into low power
// - acknowledge every valid command otherwise; the code sends no acknowledge for the ack disable command
// - handshake enable cleared by system stop or ack disable command
// - low over 128 cycles is sync, waits forever
// - no fall within 512 cycles discards command
module background_debug_mode_logic
  import bdm_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // debug wire pin
  input  wire logic debug_wire_pin_level,
  output wire logic debug_wire_pin_drive,
  output wire logic debug_wire_pin_enable,
  // software mode access
  input  wire logic sw_mode_wr,
  input  wire logic sw_mode_wdata,
  output wire logic mode_bit,
  // cpu handshake
  input  wire logic cpu_irq_pending,
  input  wire logic cpu_step_done,
  input  wire logic cpu_in_lowpower,
  input  wire logic sys_stop,
  output wire logic step_req,
  output wire logic irq_stack_req,
  output wire logic isr_entry,
  output wire logic active_debug,
  output wire logic fetch_vector,
  output wire logic periph_run,
  output wire logic ack_enabled
);
  wire_if ifc ();

  pin_sync u_sync (
    .mclk (mclk),
    .pin  (debug_wire_pin_level),
    .ifc  (ifc)
  );

  low_pulse_driver u_drv (
    .mclk (mclk),
    .rst  (rst),
    .ifc  (ifc)
  );

  core_state_t q;
  core_state_t d;
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic        want_ack;
  logic        step_exec;
  logic        bg_exec;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    d            = q;
    want_ack     = 1'b0;
    byte_done    = 1'b0;
    step_exec    = 1'b0;
    bg_exec      = 1'b0;
    rx_byte      = {q.shreg[6:0], ifc.level};
    d.rst_seen   = 1'b0;
    d.drv_go     = 1'b0;
    d.step_req   = 1'b0;
    d.irq_stack  = 1'b0;
    d.isr_entry  = 1'b0;
    d.periph_run = 1'b1;
    if (q.cnt != {CNT_W{1'b1}}) begin
      d.cnt = q.cnt + 10'h001;
    end
    // strap capture on the first cycle after reset release
    if (q.rst_seen) begin
      d.mode      = ifc.level;
      d.active    = (ifc.level == MODE_SPECIAL);
      d.fetch_vec = (ifc.level == MODE_NORMAL);
    end
    if (sw_mode_wr && sw_mode_wdata == MODE_NORMAL) begin
      d.mode = MODE_NORMAL;
    end
    case (q.state)
      ST_IDLE, ST_RX: begin
        if (ifc.fall) begin
          d.state    = ST_RX;
          d.cnt      = '0;
          d.bit_open = 1'b1;
        end
        if (q.bit_open && q.cnt == CNT_W'(RX_SAMPLE_CYC - 1)) begin
          d.bit_open = 1'b0;
          d.shreg    = rx_byte;
          d.nbits    = q.nbits + 3'h1;
          byte_done  = (q.nbits == LAST_BIT);
        end
        if (!ifc.level && !ifc.fall && q.cnt == CNT_W'(SYNC_CYC)) begin
          d.state    = ST_SYNC_WAIT;
          d.bit_open = 1'b0;
          d.nbits    = 3'h0;
          d.phase    = 1'b0;
        end else if (q.state == ST_RX && !ifc.fall &&
                     q.cnt == CNT_W'(TIMEOUT_CYC - 1)) begin
          d.state = ST_IDLE;
          d.nbits = 3'h0;
          d.phase = 1'b0;
        end
        if (byte_done && !q.phase) begin
          d.cmd = rx_byte;
          case (rx_byte)
            CMD_WRITE_MODE: begin
              d.phase = 1'b1;
            end
            CMD_ACK_ENABLE: begin
              d.ack_en = 1'b1;
              want_ack = 1'b1;
            end
            CMD_ACK_DISABLE: begin
              d.ack_en = 1'b0;
              d.state  = ST_IDLE;
            end
            CMD_BACKGROUND: begin
              bg_exec = 1'b1;
              if (!cpu_in_lowpower) begin
                d.active = 1'b1;
                want_ack = 1'b1;
              end else begin
                d.state = ST_IDLE;
              end
            end
            CMD_GO: begin
              d.active = 1'b0;
              want_ack = 1'b1;
            end
            CMD_STEP: begin
              if (q.active && !cpu_in_lowpower) begin
                step_exec   = 1'b1;
                d.step_irq  = cpu_irq_pending;
                d.irq_stack = cpu_irq_pending;
                d.step_req  = !cpu_irq_pending;
                d.state     = ST_STEP;
              end else begin
                d.state = ST_IDLE;
              end
            end
            CMD_READ_STATUS: begin
              d.shreg              = 8'h00;
              d.shreg[STAT_MODE]   = q.mode;
              d.shreg[STAT_ACK_EN] = q.ack_en;
              d.shreg[STAT_STEPLP] = q.step_lp;
              d.shreg[STAT_ACTIVE] = q.active;
              want_ack             = 1'b1;
            end
            default: begin
              d.state = ST_IDLE;
            end
          endcase
        end else if (byte_done) begin
          d.phase = 1'b0;
          if (rx_byte[WMODE_BIT] == MODE_NORMAL) begin
            d.mode = MODE_NORMAL;
          end
          want_ack = 1'b1;
        end
      end
      ST_SYNC_WAIT: begin
        if (ifc.rise) begin
          d.drv_go  = 1'b1;
          d.drv_len = LEN_W'(SYNC_RESP_CYC);
          d.state   = ST_DRAIN;
        end
      end
      ST_TX: begin
        if (ifc.fall && !ifc.drv_busy) begin
          d.cnt   = '0;
          d.shreg = {q.shreg[6:0], 1'b0};
          d.nbits = q.nbits + 3'h1;
          if (!q.shreg[7]) begin
            d.drv_go  = 1'b1;
            d.drv_len = LEN_W'(BIT0_LOW_CYC);
          end
          if (q.nbits == LAST_BIT) begin
            d.state = ST_DRAIN;
          end
        end else if (q.cnt == CNT_W'(TIMEOUT_CYC - 1)) begin
          d.state = ST_IDLE;
          d.nbits = 3'h0;
        end
      end
      ST_DRAIN: begin
        if (!q.drv_go && !ifc.drv_busy) begin
          d.state = ST_IDLE;
        end
      end
      ST_ACK_WAIT: begin
        if (q.cnt == CNT_W'(ACK_DELAY_CYC - 1)) begin
          d.drv_go  = 1'b1;
          d.drv_len = LEN_W'(ACK_LOW_CYC);
          d.state   = ST_ACK;
        end
      end
      ST_ACK: begin
        if (!q.drv_go && !ifc.drv_busy) begin
          d.state = (q.cmd == CMD_READ_STATUS) ? ST_TX : ST_IDLE;
        end
      end
      ST_STEP: begin
        if (cpu_step_done) begin
          if (cpu_in_lowpower && !q.step_irq) begin
            d.step_lp = 1'b1;
            d.active  = 1'b0;
            d.state   = ST_IDLE;
          end else begin
            d.isr_entry = q.step_irq;
            d.cnt       = '0;
            d.state     = q.ack_en ? ST_ACK_WAIT : ST_IDLE;
          end
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
    if (want_ack) begin
      d.cnt   = '0;
      d.nbits = 3'h0;
      if (d.ack_en) begin
        d.state = ST_ACK_WAIT;
      end else begin
        d.state = (d.cmd == CMD_READ_STATUS) ? ST_TX : ST_IDLE;
      end
    end
    if (q.step_lp && !cpu_in_lowpower) begin
      d.step_lp   = 1'b0;
      d.active    = 1'b1;
      d.isr_entry = 1'b1;
    end
    if (sys_stop) begin
      d.state    = ST_IDLE;
      d.ack_en   = 1'b0;
      d.bit_open = 1'b0;
      d.nbits    = 3'h0;
      d.phase    = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= CORE_RESET;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign ifc.drv_go            = q.drv_go;
  assign ifc.drv_len           = q.drv_len;
  assign debug_wire_pin_drive  = ifc.drv_out;
  assign debug_wire_pin_enable = ifc.drv_oe;
  assign mode_bit              = q.mode;
  assign step_req              = q.step_req;
  assign irq_stack_req         = q.irq_stack;
  assign isr_entry             = q.isr_entry;
  assign active_debug          = q.active;
  assign fetch_vector          = q.fetch_vec;
  assign periph_run            = q.periph_run;
  assign ack_enabled           = q.ack_en;

  ////////////////////////////////////////////////////////////////////////////

  sequence zero_low;
    (ifc.drv_oe && !ifc.drv_out) [*8] ##1 (ifc.drv_oe && !ifc.drv_out) [*5];
  endsequence

  sequence speedup_high;
    ifc.drv_oe && ifc.drv_out;
  endsequence

  chk_mode_capture: assert property (
    @(posedge mclk) disable iff (rst)
    q.rst_seen |=> (q.mode == $past(ifc.level)))
    else $error("mode bit not latched at release");

  chk_mode_limited: assert property (
    @(posedge mclk) disable iff (rst)
    (q.mode == MODE_NORMAL && !q.rst_seen) |=> (q.mode == MODE_NORMAL))
    else $error("mode bit left normal mode");

  chk_special_active: assert property (
    @(posedge mclk) disable iff (rst)
    (q.rst_seen && ifc.level == MODE_SPECIAL) |=> (q.active && !q.fetch_vec))
    else $error("special mode did not start debug");

  chk_normal_vector: assert property (
    @(posedge mclk) disable iff (rst)
    (q.rst_seen && ifc.level == MODE_NORMAL) |=> (q.fetch_vec && !q.active))
    else $error("normal mode did not fetch vector");

  chk_zero_bit_timing: assert property (
    @(posedge mclk) disable iff (rst)
    (q.drv_go && !ifc.drv_busy && q.drv_len == LEN_W'(BIT0_LOW_CYC))
    |=> zero_low ##1 speedup_high ##1 !ifc.drv_oe)
    else $error("zero bit shape wrong");

  chk_irq_step: assert property (
    @(posedge mclk) disable iff (rst)
    (step_exec && cpu_irq_pending) |=> (q.irq_stack && !q.step_req))
    else $error("pending interrupt step ran instruction");

  chk_step_lowpower: assert property (
    @(posedge mclk) disable iff (rst || sys_stop)
    (q.state == ST_STEP && cpu_step_done && cpu_in_lowpower && !q.step_irq)
    |=> (q.step_lp && q.state == ST_IDLE))
    else $error("step into low power mishandled");

  chk_bg_lowpower: assert property (
    @(posedge mclk) disable iff (rst)
    (bg_exec && cpu_in_lowpower && !q.active) |=> !q.active)
    else $error("background executed in low power");

  chk_sys_stop: assert property (
    @(posedge mclk) disable iff (rst)
    sys_stop |=> (!q.ack_en && q.state == ST_IDLE))
    else $error("command or handshake survived system stop");

  chk_lp_exit: assert property (
    @(posedge mclk) disable iff (rst)
    (q.step_lp && !cpu_in_lowpower) |=> (q.active && q.isr_entry))
    else $error("low power exit missed debug entry");

  chk_ack_pulse: assert property (
    @(posedge mclk) disable iff (rst || sys_stop)
    (q.state == ST_ACK_WAIT && q.cnt == CNT_W'(ACK_DELAY_CYC - 1))
    |=> (q.drv_go && q.drv_len == LEN_W'(ACK_LOW_CYC)) ##[1:2] ifc.drv_busy)
    else $error("acknowledge pulse not issued");

  chk_sync_wait: assert property (
    @(posedge mclk) disable iff (rst || sys_stop)
    (q.state == ST_SYNC_WAIT && !ifc.rise) |=> (q.state == ST_SYNC_WAIT))
    else $error("sync wait left without rising edge");

  chk_timeout: assert property (
    @(posedge mclk) disable iff (rst)
    (q.state == ST_RX && !ifc.fall && q.cnt == CNT_W'(TIMEOUT_CYC - 1))
    |=> (q.state == ST_IDLE && q.mode == $past(q.mode)))
    else $error("command not discarded on timeout");
endmodule

// ==== dv/debug_host_model.sv ====
// host side of the single-wire debug link: sends bits, reads answers
// assumes a pulled-up wire; bench computes the wire level from all drivers

`timescale 1ns/1ps

module debug_host_model (
  // clock
  input  wire logic mclk,
  // wire
  input  wire logic pin,
  output logic      host_low
);
  initial host_low = 1'b0;

  task automatic set_level(input logic l);
    host_low = !l;
  endtask

  // one bit: short low for 1, long low for 0, fixed 25-cycle spacing
  task automatic bit_out(input logic b);
    @(posedge mclk) #1 host_low = 1'b1;
    repeat (b ? 4 : 16) @(posedge mclk);
    #1 host_low = 1'b0;
    repeat (b ? 20 : 8) @(posedge mclk);
  endtask

  // top n bits of v, msb first
  task automatic send(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--) bit_out(v[i]);
  endtask

  // reads a byte; lo_max is the longest low seen on a zero bit
  task automatic recv(output logic [7:0] v, output int lo_max);
    int lo;
    lo_max = 0;
    for (int i = 7; i >= 0; i--) begin
      lo = 0;
      @(posedge mclk) #1 host_low = 1'b1;
      for (int k = 1; k < 24; k++) begin
        @(posedge mclk) #1;
        if (pin === 1'b0) lo++;
        if (k == 4) host_low = 1'b0;
        if (k == 10) v[i] = pin;
      end
      if (v[i] === 1'b0 && lo > lo_max) lo_max = lo;
    end
  endtask

  // counts low cycles on the wire over a window that covers an ack
  task automatic wait_ack(output int lo);
    lo = 0;
    repeat (120) begin
      @(posedge mclk) #1;
      if (pin === 1'b0) lo++;
    end
  endtask

  // long low for a sync request, then count the reply pulse
  task automatic sync_req(output int lo);
    @(posedge mclk) #1 host_low = 1'b1;
    repeat (200) @(posedge mclk);
    #1 host_low = 1'b0;
    wait_ack(lo);
    repeat (100) begin
      @(posedge mclk) #1;
      if (pin === 1'b0) lo++;
    end
  endtask
endmodule

// ==== dv/background_debug_mode_logic_tb.sv ====
// self-checking bench of the single-wire debug target logic
// assumes the host model and a pulled-up open-drain wire

`timescale 1ns/1ps

module background_debug_mode_logic_tb;
  import bdm_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, sw_wr = 1'b0, sw_wd = 1'b0;
  logic irq = 1'b0, done = 1'b0, lowp = 1'b0, sstop = 1'b0;
  logic pin, drv, en, mode, stp, stk, isr, act, fv, prun, acken, hlow;
  logic [7:0] v;
  int fail_count = 0, checks = 0, cyc = 0, n_stp, n_stk, n_isr, lo;

  initial forever #2 mclk = ~mclk;
  assign pin = (hlow || (en && !drv)) ? 1'b0 : 1'b1;

  background_debug_mode_logic dut (
    .mclk(mclk), .rst(rst), .debug_wire_pin_level(pin),
    .debug_wire_pin_drive(drv), .debug_wire_pin_enable(en),
    .sw_mode_wr(sw_wr), .sw_mode_wdata(sw_wd), .mode_bit(mode),
    .cpu_irq_pending(irq), .cpu_step_done(done),
    .cpu_in_lowpower(lowp), .sys_stop(sstop), .step_req(stp),
    .irq_stack_req(stk), .isr_entry(isr), .active_debug(act),
    .fetch_vector(fv), .periph_run(prun), .ack_enabled(acken));
  debug_host_model host (.mclk(mclk), .pin(pin), .host_low(hlow));

  always @(posedge mclk) begin
    cyc++;
    if (!rst) begin
      n_stp += stp;
      n_stk += stk;
      n_isr += isr;
    end
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic clr();
    n_stp = 0;
    n_stk = 0;
    n_isr = 0;
  endtask

  task automatic do_reset(input logic strap);
    @(posedge mclk) #1 host.set_level(strap);
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    chk(en === 1'b0, "wire driven in reset");
    rst = 1'b0;
    repeat (4) @(posedge mclk);
    #1 host.set_level(1'b1);
    chk(mode === strap, "mode strap");
    chk(act === !strap && fv === strap, "boot path");
    chk(prun === 1'b1 && acken === 1'b0, "after reset");
    repeat (4) @(posedge mclk);
  endtask

  task automatic pulse_done();
    @(posedge mclk) #1 done = 1'b1;
    @(posedge mclk) #1 done = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_boot();
    do_reset(1'b1);
    do_reset(1'b0);
    @(posedge mclk) #1 sw_wr = 1'b1;
    @(posedge mclk) #1 sw_wr = 1'b0;
    @(posedge mclk) #1;
    chk(mode === 1'b0, "zero write changed mode");
    sw_wd = 1'b1;
    sw_wr = 1'b1;
    @(posedge mclk) #1 sw_wr = 1'b0;
    chk(mode === 1'b1, "mode write to normal");
    do_reset(1'b0);
    $display("test boot done");
  endtask

  task automatic t_status();
    host.send(CMD_ACK_ENABLE, 8);
    host.wait_ack(lo);
    chk(lo > 0 && acken === 1'b1, "ack enable");
    host.send(CMD_READ_STATUS, 8);
    host.wait_ack(lo);
    chk(lo > 0, "status ack");
    host.recv(v, lo);
    chk(v[3:0] === 4'ha, "status value");
    chk(lo >= 16 && lo <= 18, "zero bit low time");
    $display("test status done");
  endtask

  task automatic t_step_irq();
    irq = 1'b1;
    clr();
    host.send(CMD_STEP, 8);
    repeat (4) @(posedge mclk);
    chk(n_stk === 1 && n_stp === 0, "stack only");
    pulse_done();
    irq = 1'b0;
    host.wait_ack(lo);
    chk(n_isr === 1 && lo > 0 && act === 1'b1, "isr entry");
    $display("test step irq done");
  endtask

  task automatic t_step_lp();
    clr();
    host.send(CMD_STEP, 8);
    repeat (4) @(posedge mclk);
    chk(n_stp === 1 && n_stk === 0, "step pulse");
    #1 lowp = 1'b1;
    pulse_done();
    host.wait_ack(lo);
    chk(lo === 0 && act === 1'b0, "step held in low power");
    host.send(CMD_BACKGROUND, 8);
    host.wait_ack(lo);
    chk(lo === 0 && act === 1'b0, "background in low power");
    host.send(CMD_READ_STATUS, 8);
    host.wait_ack(lo);
    chk(lo > 0, "ack in low power");
    host.recv(v, lo);
    chk(v[2] === 1'b1, "stepped into low power");
    #1 lowp = 1'b0;
    host.wait_ack(lo);
    chk(lo === 0 && act === 1'b1 && n_isr === 1, "exit to debug");
    chk(acken === 1'b1, "handshake kept");
    $display("test step low power done");
  endtask

  task automatic t_sync();
    host.sync_req(lo);
    chk(lo >= 127 && lo <= 131, "sync reply");
    $display("test sync done");
  endtask

  task automatic t_sys_stop();
    #1 sstop = 1'b1;
    repeat (2) @(posedge mclk);
    chk(acken === 1'b0, "handshake cleared");
    host.send(CMD_ACK_ENABLE, 8);
    host.wait_ack(lo);
    chk(lo === 0 && acken === 1'b0, "command in system stop");
    #1 sstop = 1'b0;
    repeat (20) @(posedge mclk);
    host.send(CMD_ACK_ENABLE, 8);
    host.wait_ack(lo);
    chk(lo > 0 && acken === 1'b1, "re-enable");
    $display("test system stop done");
  endtask

  task automatic t_timeout();
    host.send(CMD_ACK_DISABLE, 8);
    host.wait_ack(lo);
    chk(lo === 0 && acken === 1'b0, "ack disable");
    host.send(CMD_WRITE_MODE, 8);
    host.send(8'h01, 7);
    repeat (600) @(posedge mclk);
    chk(mode === 1'b0, "discarded command");
    host.send(CMD_WRITE_MODE, 8);
    host.send(8'h01, 8);
    repeat (4) @(posedge mclk);
    chk(mode === 1'b1, "serial mode write");
    host.send(CMD_GO, 8);
    repeat (4) @(posedge mclk);
    chk(act === 1'b0, "go left debug");
    host.send(CMD_BACKGROUND, 8);
    repeat (4) @(posedge mclk);
    chk(act === 1'b1, "background entered debug");
    $display("test timeout done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d, fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    t_boot();
    t_status();
    t_step_irq();
    t_step_lp();
    t_sync();
    t_sys_stop();
    t_timeout();
    give_verdict();
  end
endmodule
